// >>> src/usrx_pkg.sv
// package for the serial port flags, parity and receiver block
package usrx_pkg;
  localparam int unsigned clk_freq_hz = 20000000;
  localparam logic [2:0] size_nine = 3'h7; // char_size code for nine bits
  localparam logic [4:0] os_normal = 5'h10; // sixteen samples per bit
  localparam logic [4:0] os_double = 5'h08; // eight samples per bit
  localparam logic [4:0] ctr_normal = 5'h08; // first centre sample, normal
  localparam logic [4:0] ctr_double = 5'h04; // first centre sample, double
  localparam logic [1:0] rx_depth = 2'h2;
  localparam logic [3:0] one_bit = 4'h1;

  typedef enum logic [1:0] {
    USRX_IDLE,
    USRX_START,
    USRX_BITS,
    USRX_STOP
  } usrx_state_e;

  // one receive buffer entry with its own error flags
  typedef struct packed {
    logic [8:0] data;
    logic frame_error;
    logic overrun_flag;
    logic parity_error;
  } usrx_entry_s;

  // frame format shared by transmitter and receiver
  typedef struct packed {
    logic [2:0] char_size;
    logic [1:0] parity_mode_sel;
    logic double_speed;
    logic spi_mode;
  } usrx_fmt_s;
endpackage

// >>> src/usrx_top.sv
// serial port transmit flags, parity insertion and full receiver
`timescale 1ns/1ns
module usrx_top
  import usrx_pkg::*;
(
  input wire logic clock_i,
  input wire logic reset_i,
  input wire usrx_fmt_s fmt_i,
  input wire logic tx_enable_i,
  input wire logic rx_enable_i,
  input wire logic spi_master_i,
  input wire logic select_drive_en_i,
  input wire logic global_irq_en_i,
  input wire logic tx_empty_irq_en_i,
  input wire logic tx_done_irq_en_i,
  input wire logic rx_done_irq_en_i,
  input wire logic data_wr_i,
  input wire logic [8:0] data_wr_val_i,
  input wire logic tx_empty_wr_zero_i,
  input wire logic tx_done_wr_zero_i,
  input wire logic tx_done_ack_i,
  input wire logic tx_load_i,
  input wire logic tx_frame_end_i,
  input wire logic tx_busy_i,
  input wire logic sample_tick_i,
  input wire logic rxd_i,
  input wire logic data_rd_i,
  output logic [8:0] tx_data_o,
  output logic tx_parity_o,
  output logic tx_parity_ins_o,
  output logic tx_pin_own_o,
  output logic rx_pin_own_o,
  output logic select_oe_o,
  output logic tx_empty_flag_o,
  output logic tx_done_flag_o,
  output logic rx_done_flag_o,
  output logic tx_empty_irq_o,
  output logic tx_done_irq_o,
  output logic rx_done_irq_o,
  output logic [7:0] rx_data_o,
  output logic rx_ninth_bit_o,
  output logic frame_error_o,
  output logic overrun_flag_o,
  output logic parity_error_o
);

  logic tx_full_reg, tx_empty_reg, tx_done_reg, tx_own_reg;
  logic [8:0] tx_buf_reg, shift_reg;
  logic rxd_s1_reg, rxd_s2_reg, rxd_prev_reg;
  usrx_state_e state_reg;
  logic [4:0] os_cnt_reg;
  logic [1:0] vote_reg, count_reg;
  logic [3:0] bit_cnt_reg;
  logic par_acc_reg, rd_ptr_reg, wr_ptr_reg, ovr_pend_reg;
  usrx_entry_s fifo_reg [0:1];
  logic [3:0] data_bits, total_bits;
  logic [4:0] os_len, ctr_first;
  logic in_centre, last_centre, bit_val, frame_done, buf_full, rd_ok, tx_par;
  usrx_entry_s new_entry, head;

  // transmit holding buffer and its parity
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      tx_full_reg <= 1'b0;
      tx_buf_reg <= 9'h000;
    end
    else if (data_wr_i)
    begin
      tx_full_reg <= 1'b1;
      tx_buf_reg <= data_wr_val_i;
    end
    else if (tx_load_i)
      tx_full_reg <= 1'b0;
  end

  // parity spans only the selected data bits; odd mode inverts
  always_comb
  begin
    tx_par = fmt_i.parity_mode_sel[0];
    for (int i = 0; i < 9; i++)
      if (i < int'(data_bits))
        tx_par = tx_par ^ tx_buf_reg[i];
  end

  // tx_empty follows buffer; a written zero also clears, new state wins
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      tx_empty_reg <= 1'b1;
    else if (data_wr_i)
      tx_empty_reg <= 1'b0;
    else if (tx_load_i)
      tx_empty_reg <= 1'b1;
    else if (tx_empty_wr_zero_i)
      tx_empty_reg <= 1'b0;
  end

  // frame end with the buffer empty and no write sets tx_done, set beats a simultaneous clear
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      tx_done_reg <= 1'b0;
    else if (tx_frame_end_i && !tx_full_reg && !data_wr_i)
      tx_done_reg <= 1'b1;
    else if (tx_done_ack_i || tx_done_wr_zero_i)
      tx_done_reg <= 1'b0;
  end

  // pin ownership released only once the shifter goes quiet
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
      tx_own_reg <= 1'b0;
    else if (tx_enable_i)
      tx_own_reg <= 1'b1;
    else if (!tx_busy_i && !tx_full_reg)
      tx_own_reg <= 1'b0;
  end

  // two-stage synchroniser, presets high so an idle line reads one
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      rxd_s1_reg <= 1'b1;
      rxd_s2_reg <= 1'b1;
      rxd_prev_reg <= 1'b1;
    end
    else
    begin
      rxd_s1_reg <= rxd_i;
      rxd_s2_reg <= rxd_s1_reg;
      if (sample_tick_i)
        rxd_prev_reg <= rxd_s2_reg;
    end
  end

  // frame geometry from the format fields
  always_comb
  begin
    data_bits = (fmt_i.char_size == size_nine) ? 4'h9 : ({1'b0, fmt_i.char_size} + 4'h5);
    total_bits = data_bits + (fmt_i.parity_mode_sel[1] ? one_bit : 4'h0);
    os_len = fmt_i.double_speed ? os_double : os_normal;
    ctr_first = fmt_i.double_speed ? ctr_double : ctr_normal;
    in_centre = (os_cnt_reg >= ctr_first) && (os_cnt_reg <= ctr_first + 5'h02);
    last_centre = os_cnt_reg == ctr_first + 5'h02;
    bit_val = (vote_reg + {1'b0, rxd_s2_reg}) >= 2'h2;
  end

  // oversampling receiver; disabling it drops the frame at once
  always_ff @(posedge clock_i)
  begin
    if (reset_i || !rx_enable_i)
    begin
      state_reg <= USRX_IDLE;
      os_cnt_reg <= 5'h00;
      vote_reg <= 2'h0;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 9'h000;
      par_acc_reg <= 1'b0;
    end
    else if (sample_tick_i)
    begin
      if (state_reg != USRX_IDLE)
      begin
        os_cnt_reg <= (os_cnt_reg == os_len) ? 5'h01 : os_cnt_reg + 5'h01;
        if (os_cnt_reg == os_len)
          vote_reg <= 2'h0;
        else if (in_centre && !last_centre)
          vote_reg <= vote_reg + {1'b0, rxd_s2_reg};
      end
      case (state_reg)
        USRX_IDLE:
          if (rxd_prev_reg && !rxd_s2_reg)
          begin
            state_reg <= USRX_START;
            os_cnt_reg <= 5'h02; // falling edge counts as sample one
            vote_reg <= 2'h0;
          end
        USRX_START:
          if (last_centre)
          begin
            if (bit_val)
              state_reg <= USRX_IDLE; // false start, hunt again
            else
            begin
              state_reg <= USRX_BITS;
              bit_cnt_reg <= 4'h0;
              par_acc_reg <= fmt_i.parity_mode_sel[0];
            end
          end
        USRX_BITS:
          if (last_centre)
          begin
            if (bit_cnt_reg < data_bits)
              shift_reg[bit_cnt_reg] <= bit_val;
            par_acc_reg <= par_acc_reg ^ bit_val; // data and parity bits, zero when parity agrees
            bit_cnt_reg <= bit_cnt_reg + one_bit;
            if (bit_cnt_reg + one_bit == total_bits)
              state_reg <= USRX_STOP;
          end
        USRX_STOP:
          if (last_centre)
            state_reg <= USRX_IDLE;
        default:
          state_reg <= USRX_IDLE;
      endcase
    end
  end

  // completion on the first stop bit centre
  always_comb
  begin
    frame_done = sample_tick_i && rx_enable_i && (state_reg == USRX_STOP) && last_centre;
    buf_full = count_reg == rx_depth;
    rd_ok = data_rd_i && (count_reg != 2'h0);
    new_entry.data = shift_reg;
    if (fmt_i.char_size != size_nine)
      new_entry.data[8] = 1'b0;
    new_entry.frame_error = !bit_val && !fmt_i.spi_mode; // stop bit majority
    new_entry.overrun_flag = ovr_pend_reg && !fmt_i.spi_mode;
    new_entry.parity_error = fmt_i.parity_mode_sel[1] && par_acc_reg && !fmt_i.spi_mode;
    head = fifo_reg[rd_ptr_reg];
  end

  // overrun: a lost frame marks the next stored entry until a read
  always_ff @(posedge clock_i)
  begin
    if (reset_i || !rx_enable_i)
      ovr_pend_reg <= 1'b0;
    else if (frame_done && buf_full && !rd_ok)
      ovr_pend_reg <= 1'b1;
    else if (frame_done)
      ovr_pend_reg <= 1'b0; // mark handed over to the entry just stored
  end

  // two-entry receive buffer with its error flags per entry
  always_ff @(posedge clock_i)
  begin
    if (reset_i || !rx_enable_i)
    begin
      rd_ptr_reg <= 1'b0;
      wr_ptr_reg <= 1'b0;
      count_reg <= 2'h0;
    end
    else
    begin
      if (frame_done && (!buf_full || rd_ok))
      begin
        fifo_reg[wr_ptr_reg] <= new_entry;
        wr_ptr_reg <= ~wr_ptr_reg;
      end
      if (rd_ok)
        rd_ptr_reg <= ~rd_ptr_reg;
      if (frame_done && !buf_full && !rd_ok)
        count_reg <= count_reg + 2'h1;
      else if (rd_ok && !frame_done)
        count_reg <= count_reg - 2'h1;
    end
  end

  // outputs registered from the live state
  always_ff @(posedge clock_i)
  begin
    if (reset_i)
    begin
      tx_data_o <= 9'h000;
      tx_parity_o <= 1'b0;
      tx_parity_ins_o <= 1'b0;
      tx_pin_own_o <= 1'b0;
      rx_pin_own_o <= 1'b0;
      select_oe_o <= 1'b0;
      tx_empty_flag_o <= 1'b1;
      tx_done_flag_o <= 1'b0;
      rx_done_flag_o <= 1'b0;
      tx_empty_irq_o <= 1'b0;
      tx_done_irq_o <= 1'b0;
      rx_done_irq_o <= 1'b0;
      rx_data_o <= 8'h00;
      rx_ninth_bit_o <= 1'b0;
      frame_error_o <= 1'b0;
      overrun_flag_o <= 1'b0;
      parity_error_o <= 1'b0;
    end
    else
    begin
      tx_data_o <= tx_buf_reg;
      tx_parity_o <= tx_par;
      tx_parity_ins_o <= fmt_i.parity_mode_sel[1];
      tx_pin_own_o <= tx_own_reg;
      rx_pin_own_o <= rx_enable_i;
      select_oe_o <= fmt_i.spi_mode && spi_master_i && select_drive_en_i;
      tx_empty_flag_o <= tx_empty_reg;
      tx_done_flag_o <= tx_done_reg;
      rx_done_flag_o <= count_reg != 2'h0;
      tx_empty_irq_o <= tx_empty_reg && tx_empty_irq_en_i && global_irq_en_i;
      tx_done_irq_o <= tx_done_reg && tx_done_irq_en_i && global_irq_en_i;
      rx_done_irq_o <= (count_reg != 2'h0) && rx_done_irq_en_i && global_irq_en_i;
      rx_data_o <= head.data[7:0];
      rx_ninth_bit_o <= head.data[8] && (count_reg != 2'h0);
      frame_error_o <= head.frame_error && (count_reg != 2'h0) && !fmt_i.spi_mode;
      overrun_flag_o <= head.overrun_flag && (count_reg != 2'h0) && !fmt_i.spi_mode;
      parity_error_o <= head.parity_error && (count_reg != 2'h0) && fmt_i.parity_mode_sel[1];
    end
  end

  // flag mirrors buffer occupancy one cycle later
  a_rx_done_level: assert property (@(posedge clock_i) disable iff (reset_i)
    rx_done_flag_o == ($past(count_reg) != 2'h0))
    else $error("rx_done flag does not track buffer");
  a_rx_flush: assert property (@(posedge clock_i) disable iff (reset_i)
    !rx_enable_i |=> count_reg == 2'h0 ##1 !rx_done_flag_o)
    else $error("buffer not flushed on disable");
  a_tx_empty_irq: assert property (@(posedge clock_i) disable iff (reset_i)
    tx_empty_irq_o |-> $past(tx_empty_reg) && $past(global_irq_en_i))
    else $error("tx empty irq without cause");
  a_tx_empty_write: assert property (@(posedge clock_i) disable iff (reset_i)
    data_wr_i |=> !tx_empty_reg ##1 !tx_empty_flag_o)
    else $error("tx empty stays set after write");
  a_tx_done_clear: assert property (@(posedge clock_i) disable iff (reset_i)
    tx_done_ack_i && !tx_frame_end_i |=> !tx_done_reg)
    else $error("tx done not cleared by ack");
  a_tx_done_set: assert property (@(posedge clock_i) disable iff (reset_i)
    tx_frame_end_i && !tx_full_reg && !data_wr_i |=> tx_done_reg ##1 tx_done_flag_o)
    else $error("tx done not set at frame end");
  a_count_bound: assert property (@(posedge clock_i) disable iff (reset_i)
    count_reg <= rx_depth)
    else $error("receive buffer over depth");
  sequence s_lost_frame;
    frame_done && buf_full && !rd_ok;
  endsequence
  a_overrun_mark: assert property (@(posedge clock_i) disable iff (reset_i)
    s_lost_frame |=> ovr_pend_reg && count_reg == rx_depth)
    else $error("overrun not recorded");
  a_parity_off: assert property (@(posedge clock_i) disable iff (reset_i)
    !$past(fmt_i.parity_mode_sel[1]) |-> !parity_error_o)
    else $error("parity error with parity off");
  a_tx_release: assert property (@(posedge clock_i) disable iff (reset_i)
    tx_busy_i && !tx_enable_i && tx_own_reg |=> tx_own_reg)
    else $error("tx pin released mid frame");

endmodule

// >>> verif/usrx_remote_dev.sv
// remote asynchronous serial sender driving the receive pin
`timescale 1ns/1ns
module usrx_remote_dev
  import usrx_pkg::*;
(
  input wire logic clock_i,
  input wire logic sample_tick_i,
  input wire logic double_speed_i,
  output logic rxd_o
);
  // idle line sits high, as a pulled-up wire would
  initial rxd_o = 1'b1;

  // hold one level for a count of oversample ticks, then step off the edge
  task automatic hold(input logic v, input int ticks);
    int n;
    n = 0;
    rxd_o = v;
    while (n < ticks)
    begin
      @(posedge clock_i);
      if (sample_tick_i === 1'b1)
        n++;
    end
    #1;
  endtask

  // start, data lsb first, optional parity, one stop, then a bit of idle
  task automatic send(input logic [8:0] d, input int n, input logic pen, input logic par, input logic stop);
    int k;
    int w;
    w = double_speed_i ? 8 : 16;
    hold(1'b0, w);
    for (k = 0; k < n; k++)
      hold(d[k], w);
    if (pen)
      hold(par, w);
    hold(stop, w);
    hold(1'b1, w);
  endtask
endmodule

// >>> verif/usrx_top_tb.sv
// self-checking bench for the serial flags and receiver block
`timescale 1ns/1ns
module usrx_top_tb
  import usrx_pkg::*;
;
  logic clock = 1'b0;
  logic reset = 1'b1;
  usrx_fmt_s fmt = '0;
  logic tx_enable = 1'b1, rx_enable = 1'b1, spi_master = 1'b0, select_drive_en = 1'b0;
  logic global_irq_en = 1'b0, tx_empty_irq_en = 1'b0, tx_done_irq_en = 1'b0, rx_done_irq_en = 1'b0;
  logic data_wr = 1'b0, tx_empty_wr_zero = 1'b0, tx_done_wr_zero = 1'b0, tx_done_ack = 1'b0;
  logic tx_load = 1'b0, tx_frame_end = 1'b0, tx_busy = 1'b0, sample_tick = 1'b0, data_rd = 1'b0;
  logic [8:0] data_wr_val = 9'h0a7;
  logic [1:0] tick_cnt = 2'h0;
  logic rxd;
  logic [8:0] tx_data;
  logic tx_parity, tx_parity_ins, tx_pin_own, rx_pin_own, select_oe;
  logic tx_empty_flag, tx_done_flag, rx_done_flag, tx_empty_irq, tx_done_irq, rx_done_irq;
  logic [7:0] rx_data;
  logic rx_ninth_bit, frame_error, overrun_flag, parity_error;
  int failures = 0;
  int cmp_count = 0;

  usrx_top usrx_top_i (.clock_i(clock), .reset_i(reset), .fmt_i(fmt), .tx_enable_i(tx_enable),
    .rx_enable_i(rx_enable), .spi_master_i(spi_master), .select_drive_en_i(select_drive_en),
    .global_irq_en_i(global_irq_en), .tx_empty_irq_en_i(tx_empty_irq_en), .tx_done_irq_en_i(tx_done_irq_en),
    .rx_done_irq_en_i(rx_done_irq_en), .data_wr_i(data_wr), .data_wr_val_i(data_wr_val),
    .tx_empty_wr_zero_i(tx_empty_wr_zero), .tx_done_wr_zero_i(tx_done_wr_zero), .tx_done_ack_i(tx_done_ack),
    .tx_load_i(tx_load), .tx_frame_end_i(tx_frame_end), .tx_busy_i(tx_busy), .sample_tick_i(sample_tick),
    .rxd_i(rxd), .data_rd_i(data_rd), .tx_data_o(tx_data), .tx_parity_o(tx_parity),
    .tx_parity_ins_o(tx_parity_ins), .tx_pin_own_o(tx_pin_own), .rx_pin_own_o(rx_pin_own),
    .select_oe_o(select_oe), .tx_empty_flag_o(tx_empty_flag), .tx_done_flag_o(tx_done_flag),
    .rx_done_flag_o(rx_done_flag), .tx_empty_irq_o(tx_empty_irq), .tx_done_irq_o(tx_done_irq),
    .rx_done_irq_o(rx_done_irq), .rx_data_o(rx_data), .rx_ninth_bit_o(rx_ninth_bit),
    .frame_error_o(frame_error), .overrun_flag_o(overrun_flag), .parity_error_o(parity_error));

  usrx_remote_dev usrx_remote_dev_i (.clock_i(clock), .sample_tick_i(sample_tick),
    .double_speed_i(fmt.double_speed), .rxd_o(rxd));

  // clock and an oversample tick every fourth cycle
  always #25 clock = ~clock;
  always @(posedge clock)
  begin
    #1;
    tick_cnt = tick_cnt + 2'h1;
    sample_tick = (tick_cnt == 2'h0);
  end

  task automatic stop_test();
    if (failures == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic chk(input logic [8:0] got, input logic [8:0] exp);
    cmp_count++;
    if (got !== exp)
    begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask

  // one-cycle strobe, launched just after an edge
  task automatic pulse(ref logic s);
    s = 1'b1;
    cyc(1);
    s = 1'b0;
    cyc(3);
  endtask

  // one frame in, check the head entry, read it and see the buffer empty
  task automatic rx_one(input logic [8:0] d, input logic bad, input logic stop);
    int n;
    logic [8:0] m;
    logic p;
    n = (fmt.char_size == size_nine) ? 9 : 5 + int'(fmt.char_size);
    m = 9'((1 << n) - 1);
    p = (^(d & m)) ^ fmt.parity_mode_sel[0] ^ bad;
    usrx_remote_dev_i.send(d, n, fmt.parity_mode_sel[1], p, stop);
    chk(9'(rx_done_flag), 9'h1);
    chk(9'(rx_data) & m, d & m & 9'h0ff);
    if (n == 9)
      chk(9'(rx_ninth_bit), 9'(d[8]));
    chk(9'(frame_error), 9'(!stop && !fmt.spi_mode));
    chk(9'(parity_error), 9'(bad & fmt.parity_mode_sel[1]));
    pulse(data_rd);
    chk(9'(rx_done_flag), 9'h0);
  endtask

  task automatic t_tx_flags();
    global_irq_en = 1'b1;
    tx_empty_irq_en = 1'b1;
    tx_done_irq_en = 1'b1;
    fmt = '{char_size: 3'h3, parity_mode_sel: 2'h2, default: 1'b0};
    cyc(3);
    chk(9'(tx_empty_irq), 9'h1);
    pulse(data_wr);
    chk(9'(tx_empty_flag), 9'h0);
    chk(9'(tx_empty_irq), 9'h0);
    chk(tx_data, 9'h0a7);
    tx_busy = 1'b1;
    pulse(tx_load);
    chk(9'(tx_empty_flag), 9'h1);
    chk(9'(tx_parity_ins), 9'h1);
    chk(9'(tx_parity), 9'h1);
    // odd mode inverts the same data parity
    fmt.parity_mode_sel = 2'h3;
    cyc(3);
    chk(9'(tx_parity), 9'h0);
    pulse(tx_empty_wr_zero);
    chk(9'(tx_empty_flag), 9'h0);
    // disable while a frame is still shifting: the pin stays ours
    tx_enable = 1'b0;
    cyc(3);
    chk(9'(tx_pin_own), 9'h1);
    tx_busy = 1'b0;
    pulse(tx_frame_end);
    chk(9'(tx_done_flag), 9'h1);
    chk(9'(tx_done_irq), 9'h1);
    chk(9'(tx_pin_own), 9'h0);
    tx_done_irq_en = 1'b0;
    cyc(3);
    chk(9'(tx_done_irq), 9'h0);
    pulse(tx_done_ack);
    chk(9'(tx_done_flag), 9'h0);
    pulse(tx_frame_end);
    chk(9'(tx_done_flag), 9'h1);
    pulse(tx_done_wr_zero);
    chk(9'(tx_done_flag), 9'h0);
  endtask

  task automatic t_pins();
    fmt.spi_mode = 1'b1;
    spi_master = 1'b1;
    select_drive_en = 1'b1;
    cyc(3);
    chk(9'(select_oe), 9'h1);
    spi_master = 1'b0;
    cyc(3);
    chk(9'(select_oe), 9'h0);
    chk(9'(rx_pin_own), 9'h1);
    fmt.spi_mode = 1'b0;
  endtask

  task automatic t_rx_formats();
    rx_done_irq_en = 1'b1;
    fmt = '{char_size: 3'h3, default: 1'b0};
    rx_one(9'h0b4, 1'b0, 1'b1);
    rx_one(9'h05a, 1'b0, 1'b0);
    // in SPI mode a bad stop bit must not raise frame_error
    fmt.spi_mode = 1'b1;
    rx_one(9'h05a, 1'b0, 1'b0);
    fmt.spi_mode = 1'b0;
    fmt.double_speed = 1'b1;
    rx_one(9'h0c9, 1'b0, 1'b1);
    fmt = '{char_size: 3'h3, parity_mode_sel: 2'h2, default: 1'b0};
    rx_one(9'h0a7, 1'b0, 1'b1);
    rx_one(9'h0a7, 1'b1, 1'b1);
    fmt.parity_mode_sel = 2'h3;
    rx_one(9'h031, 1'b1, 1'b1);
    fmt = '{char_size: size_nine, default: 1'b0};
    rx_one(9'h1c3, 1'b0, 1'b1);
    fmt.char_size = 3'h0;
    rx_one(9'h015, 1'b0, 1'b1);
  endtask

  task automatic t_glitch();
    fmt = '{char_size: 3'h3, default: 1'b0};
    // low for only three samples: the centre vote must reject it
    usrx_remote_dev_i.hold(1'b0, 3);
    usrx_remote_dev_i.hold(1'b1, 32);
    chk(9'(rx_done_flag), 9'h0);
    rx_one(9'h066, 1'b0, 1'b1);
  endtask

  task automatic t_overrun();
    usrx_remote_dev_i.send(9'h011, 8, 1'b0, 1'b0, 1'b1);
    usrx_remote_dev_i.send(9'h022, 8, 1'b0, 1'b0, 1'b1);
    usrx_remote_dev_i.send(9'h033, 8, 1'b0, 1'b0, 1'b1);
    chk(9'(rx_data), 9'h011);
    chk(9'(rx_done_irq), 9'h1);
    pulse(data_rd);
    chk(9'(overrun_flag), 9'h0);
    chk(9'(rx_data), 9'h022);
    usrx_remote_dev_i.send(9'h044, 8, 1'b0, 1'b0, 1'b1);
    pulse(data_rd);
    chk(9'(overrun_flag), 9'h1);
    chk(9'(rx_data), 9'h044);
    usrx_remote_dev_i.send(9'h055, 8, 1'b0, 1'b0, 1'b1);
    // switching the receiver off flushes both entries at once
    rx_enable = 1'b0;
    cyc(3);
    chk(9'(rx_done_flag), 9'h0);
    chk(9'(rx_done_irq), 9'h0);
    chk(9'(rx_pin_own), 9'h0);
  endtask

  // watchdog well beyond the expected run length
  initial
  begin
    #3000000;
    failures++;
    stop_test();
  end

  initial
  begin
    cyc(3);
    reset = 1'b0;
    cyc(1);
    chk(9'(tx_empty_flag), 9'h1);
    chk(9'(rx_done_flag), 9'h0);
    t_tx_flags();
    t_pins();
    t_rx_formats();
    t_glitch();
    t_overrun();
    stop_test();
  end
endmodule
